//--- src/cpc_pkg.sv
package cpc_pkg;

    // ****************************************
    // modes and widths
    // ****************************************
    typedef enum logic [2:0] {
        output_voltage_mode,
        output_current_mode,
        input_voltage_mode,
        input_current_mode,
        rtd_tc_mode
    } cpc_mode_t;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 24;
    localparam int FRAME_BITS_PLAIN = 32;
    localparam int FRAME_BITS_CHK = 40;
    localparam int CHK_W = 8;
    localparam int NUM_INPUTS = 8;

    // input port bit positions in the in-use mask
    localparam int SENSE_ONE_BIT = 0;
    localparam int SENSE_TWO_BIT = 1;
    localparam int SENSE_THREE_BIT = 2;
    localparam int COLD_A_BIT = 6;
    localparam int COLD_B_BIT = 7;

    // range scaling in percent of nominal
    localparam int FULL_SCALE_PCT = 125;
    localparam int LINEAR_PCT = 105;

    // general configuration register layout (own placement)
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_WIRING_BIT = 4;
    localparam int CFG_CHK_EN_BIT = 5;
    localparam logic [DATA_W-1:0] CFG_RESET = 24'h000000;
    localparam logic [DATA_W-1:0] INT_EN_RESET = 24'h000000;
    localparam logic [DATA_W-1:0] DAC_RESET = 24'h000000;

    // register addresses (own placement)
    localparam logic [ADDR_W-1:0] ADDR_CFG = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 7'h02;
    localparam logic [ADDR_W-1:0] ADDR_INT_EN = 7'h03;
    localparam logic [ADDR_W-1:0] ADDR_DAC = 7'h04;
    localparam logic [ADDR_W-1:0] ADDR_ADC = 7'h05;

    // interrupt status bit positions
    localparam int INT_RDY_BIT = 0;
    localparam int INT_LOAD_BIT = 1;

    // link clock timing
    localparam real LINK_CLK_NS = 1.0e3 / 7.3728;
    localparam real MCLK_NS = 5.0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic [DATA_W-1:0] data;
    } cpc_cmd_t;

    typedef struct packed {
        logic sync;
        logic load_n;
        logic rst_n;
    } cpc_strobe_t;

endpackage

//--- src/cpc_sync2.sv
`timescale 1ns/10ps
module cpc_sync2
    import cpc_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    initial begin
        if (W < 1) $error("width must be positive");
    end

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

//--- src/cpc_core.sv
`timescale 1ns/10ps
// What this block does
// [R1] host feeds the optional external clock at 7.3728MHz
// [R2] sync input resets modulator and filter state
// [R3] ready goes low when a new conversion result exists
// [R4] reading a sample returns ready high; ready always driven
// [R5] open-drain interrupt pulls low from status and enable registers
// [R6] reset low restores defaults, floats output, stops conversion
// [R7] serial data output floats while chip select is high
// [R8] serial activity ignored unless chip select is low
// [R9] load strobe low moves dac data register to the output
// [R10] load strobe ignored while reset input is low
// [R11] five modes selected in the general configuration register
// [R12] mode decides inputs in use; conversion independent of output
// [R13] current output reserves inputs one, two; voltage uses three
// [R14] both auxiliary inputs always available for conversion
// [R15] wiring bit enables the safety feedback switch
// [R16] full scale 125 percent, linear 105 percent of nominal
// [R17] host halves dac codes, doubles adc codes for narrow ranges
// [R18] frame is 7-bit address, read/write bit, 24-bit payload
// [R19] frame is four bytes, five with checksum enabled
// [R20] sync, load and reset inputs pass a two-stage synchroniser
module cpc_core
    import cpc_pkg::*;
#(
    parameter int DIV = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // host strobes
    input wire logic sync_in,
    input wire logic dac_load_strobe_n,
    input wire logic rst_pin_n,
    output logic ready_n,
    output logic int_o,
    output logic int_oe,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    // analog side
    input wire logic [DATA_W-1:0] adc_result,
    output logic [DATA_W-1:0] dac_out,
    output logic dac_out_en,
    output logic [NUM_INPUTS-1:0] inputs_in_use,
    output logic [NUM_INPUTS-1:0] inputs_free,
    output logic wiring_switch_on,
    output logic adc_run,
    output logic filter_clear
);
    // ****************************************
    // synchronisers
    // ****************************************
    logic [5:0] raw;
    logic [5:0] syn;
    // active-low pins pass inverted so reset leaves them at idle
    assign raw = {sync_in, !dac_load_strobe_n, !rst_pin_n, sclk, !cs_n, sdi};

    cpc_sync2 #(.W(6)) cpc_sync2_inst (  // [R20]
        .mclk(mclk),
        .resetn(resetn),
        .async_in(raw),
        .sync_out(syn)
    );

    logic s_sync, s_load_n, s_rst_n, s_sclk, s_cs_n, s_sdi;
    logic s_load, s_rst, s_cs;
    assign {s_sync, s_load, s_rst, s_sclk, s_cs, s_sdi} = syn;
    assign s_load_n = !s_load;
    assign s_rst_n = !s_rst;
    assign s_cs_n = !s_cs;

    initial begin
        if (DIV < 2 || DIV > 65536) $error("divider out of range");
    end

    // ****************************************
    // state
    // ****************************************
    logic [DATA_W-1:0] cfg_q, cfg_d, inten_q, inten_d, dac_q, dac_d;
    logic [DATA_W-1:0] istat_q, istat_d;
    logic [DATA_W-1:0] sample_q, sample_d;
    logic [39:0] shift_q, shift_d, tx_q, tx_d;
    logic [5:0] cnt_q, cnt_d;
    logic sclk_q, sclk_d, load_n_q, load_n_d, rdy_n_q, rdy_n_d;
    logic dac_en_q, dac_en_d, run_q, run_d, clr_q, clr_d;
    logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d, int_q, int_d;
    logic [15:0] div_q, div_d;
    logic [NUM_INPUTS-1:0] use_q, use_d;
    logic wsw_q, wsw_d;

    function automatic logic [NUM_INPUTS-1:0] use_mask(
        input logic [2:0] m
    );
        logic [NUM_INPUTS-1:0] r;
        r = '0;
        r[COLD_A_BIT] = 1'b0;
        case (cpc_mode_t'(m))
            output_current_mode: begin
                r[SENSE_ONE_BIT] = 1'b1;  // [R13]
                r[SENSE_TWO_BIT] = 1'b1;
            end
            output_voltage_mode: r[SENSE_THREE_BIT] = 1'b1;  // [R13]
            default: r = '0;
        endcase
        return r;
    endfunction

    logic rise, fall, frame_end, sample_ev, rd_sample;
    logic chk_en;
    cpc_cmd_t cmd;
    logic [5:0] frame_len;

    always_comb begin
        chk_en = cfg_q[CFG_CHK_EN_BIT];
        frame_len = 6'(FRAME_BITS_PLAIN);  // [R19]
        if (chk_en) frame_len = 6'(FRAME_BITS_CHK);
        rise = s_sclk && !sclk_q && !s_cs_n;  // [R8]
        fall = !s_sclk && sclk_q && !s_cs_n;
        shift_d = shift_q;
        cnt_d = cnt_q;
        tx_d = tx_q;
        cfg_d = cfg_q;
        inten_d = inten_q;
        dac_d = dac_q;
        istat_d = istat_q;
        frame_end = 1'b0;
        cmd = '0;
        if (s_cs_n) begin
            cnt_d = '0;  // [R8]
        end else if (rise) begin
            shift_d = {shift_q[38:0], s_sdi};
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == 6'h07) begin
                case (shift_q[6:0])
                    ADDR_CFG: tx_d = {cfg_q, 16'h0000};
                    ADDR_INT_STAT: tx_d = {istat_q, 16'h0000};
                    ADDR_INT_EN: tx_d = {inten_q, 16'h0000};
                    ADDR_DAC: tx_d = {dac_q, 16'h0000};
                    ADDR_ADC: tx_d = {sample_q, 16'h0000};
                    default: tx_d = '0;
                endcase
            end
            if (cnt_q + 6'h01 == frame_len) begin
                frame_end = 1'b1;
            end
        end else if (fall && cnt_q >= 6'h09) begin
            tx_d = {tx_q[38:0], 1'b0};
        end
        // frame layout: address, read/write, payload
        if (chk_en) begin
            cmd = cpc_cmd_t'(shift_d[39:8]);  // [R18]
        end else begin
            cmd = cpc_cmd_t'(shift_d[31:0]);  // [R18]
        end
        rd_sample = frame_end && !cmd.wr && cmd.addr == ADDR_ADC;
        if (frame_end && cmd.wr) begin
            case (cmd.addr)
                ADDR_CFG: cfg_d = cmd.data;  // [R11]
                ADDR_INT_EN: inten_d = cmd.data;
                ADDR_DAC: dac_d = cmd.data;
                ADDR_INT_STAT: istat_d = istat_q & ~cmd.data;
                default: cfg_d = cfg_q;
            endcase
        end
        // sample and load events set status; set wins over clear
        if (sample_ev) istat_d[INT_RDY_BIT] = 1'b1;
        if (!s_load_n && load_n_q && s_rst_n) istat_d[INT_LOAD_BIT] = 1'b1;
        // sdo floats unless selected
        sdo_d = tx_q[39];
        sdo_oe_d = !s_cs_n;  // [R7]
    end

    // conversion engine on divided rate
    always_comb begin
        sclk_d = s_sclk;
        load_n_d = s_load_n;
        div_d = (div_q == 16'(DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
        run_d = s_rst_n;  // [R6]
        clr_d = s_sync || !s_rst_n;  // [R2]
        if (clr_q) div_d = 16'h0000;  // [R2]
        sample_ev = run_q && !clr_q && div_q == 16'(DIV - 1);
        sample_d = sample_ev ? adc_result : sample_q;
        rdy_n_d = rdy_n_q;
        if (sample_ev) rdy_n_d = 1'b0;  // [R3]
        else if (rd_sample) rdy_n_d = 1'b1;  // [R4]
        if (!s_rst_n) rdy_n_d = 1'b1;
        dac_en_d = dac_en_q;
        if (!s_load_n && load_n_q && s_rst_n) begin  // [R10]
            dac_en_d = 1'b1;  // [R9]
        end
        if (!s_rst_n) dac_en_d = 1'b0;  // [R6]
        use_d = use_mask(cfg_q[CFG_MODE_LSB +: 3]);  // [R12]
        use_d[COLD_A_BIT] = 1'b0;  // [R14]
        use_d[COLD_B_BIT] = 1'b0;
        wsw_d = cfg_q[CFG_WIRING_BIT];  // [R15]
        int_d = |(istat_q & inten_q);  // [R5]
    end

    logic load_fire;
    assign load_fire = !s_load_n && load_n_q && s_rst_n;
    logic [DATA_W-1:0] dac_hold_d;
    always_comb begin
        dac_hold_d = load_fire ? dac_q : dac_out;  // [R9]
        if (!s_rst_n) dac_hold_d = DAC_RESET;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= CFG_RESET;
            inten_q <= INT_EN_RESET;
            dac_q <= DAC_RESET;
            istat_q <= '0;
            sample_q <= '0;
            shift_q <= '0;
            tx_q <= '0;
            cnt_q <= '0;
            sclk_q <= 1'b0;
            load_n_q <= 1'b1;
            rdy_n_q <= 1'b1;
            dac_en_q <= 1'b0;
            run_q <= 1'b0;
            clr_q <= 1'b1;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            int_q <= 1'b0;
            div_q <= '0;
            use_q <= '0;
            wsw_q <= 1'b0;
            dac_out <= DAC_RESET;
        end else if (!s_rst_n) begin  // [R6]
            cfg_q <= CFG_RESET;
            inten_q <= INT_EN_RESET;
            dac_q <= DAC_RESET;
            istat_q <= '0;
            cnt_q <= '0;
            rdy_n_q <= 1'b1;
            dac_en_q <= 1'b0;
            run_q <= 1'b0;
            clr_q <= 1'b1;
            int_q <= 1'b0;
            sdo_oe_q <= sdo_oe_d;
            sdo_q <= sdo_d;
            sclk_q <= sclk_d;
            load_n_q <= load_n_d;
            dac_out <= DAC_RESET;
            use_q <= '0;
            wsw_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            inten_q <= inten_d;
            dac_q <= dac_d;
            istat_q <= istat_d;
            sample_q <= sample_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            sclk_q <= sclk_d;
            load_n_q <= load_n_d;
            rdy_n_q <= rdy_n_d;
            dac_en_q <= dac_en_d;
            run_q <= run_d;
            clr_q <= clr_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
            int_q <= int_d;
            div_q <= div_d;
            use_q <= use_d;
            wsw_q <= wsw_d;
            dac_out <= dac_hold_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign ready_n = rdy_n_q;  // [R4]
    assign int_o = 1'b0;
    assign int_oe = int_q;  // [R5]
    assign sdo_o = sdo_q;
    assign sdo_oe = sdo_oe_q;
    assign dac_out_en = dac_en_q;
    assign inputs_in_use = use_q;
    assign inputs_free = ~use_q;  // [R14]
    assign wiring_switch_on = wsw_q;
    assign adc_run = run_q;
    assign filter_clear = clr_q;

    // ****************************************
    // assertions
    // ****************************************
    a_sdo_float: assert property ( // [R7]
        @(posedge mclk) disable iff (!resetn)
        $past(s_cs_n) |-> !sdo_oe)
        else $error("sdo driven while deselected");
    a_ready_set: assert property ( // [R3]
        @(posedge mclk) disable iff (!resetn)
        sample_ev && s_rst_n |=> !ready_n)
        else $error("ready not low");
    a_ready_clr: assert property ( // [R4]
        @(posedge mclk) disable iff (!resetn)
        rd_sample && !sample_ev && s_rst_n |=> ready_n)
        else $error("ready stuck");
    a_int_gate: assert property ( // [R5]
        @(posedge mclk) disable iff (!resetn)
        s_rst_n && $past(s_rst_n) |-> int_oe == $past(|(istat_q & inten_q)))
        else $error("interrupt mismatch");
    a_reset_stop: assert property ( // [R6]
        @(posedge mclk) disable iff (!resetn)
        !s_rst_n |=> !dac_out_en && !adc_run)
        else $error("reset ignored");
    a_load_block: assert property ( // [R10]
        @(posedge mclk) disable iff (!resetn)
        !s_rst_n |=> dac_out == DAC_RESET)
        else $error("load under reset");
    a_load_move: assert property ( // [R9]
        @(posedge mclk) disable iff (!resetn)
        load_fire |=> dac_out == $past(dac_q) && dac_out_en)
        else $error("dac not loaded");
    a_sync_clear: assert property ( // [R2]
        @(posedge mclk) disable iff (!resetn)
        s_sync |=> filter_clear ##1 !sample_ev)
        else $error("sync missed");
    a_aux_free: assert property ( // [R14]
        @(posedge mclk) disable iff (!resetn)
        inputs_free[COLD_A_BIT] && inputs_free[COLD_B_BIT])
        else $error("aux taken");
    c_sample: cover property (@(posedge mclk) sample_ev ##[1:1000] rd_sample);
    c_load: cover property (@(posedge mclk) load_fire);
    c_frame: cover property (@(posedge mclk) frame_end && cmd.wr);
endmodule

//--- tb/cpc_host.sv
`timescale 1ns/10ps
// ****************************************
// host side of the serial link
// ****************************************
module cpc_host
    import cpc_pkg::*;
(
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    logic miso;

    // miso has a pull-up while the device floats it
    assign miso = sdo_oe ? sdo_o : 1'b1;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // one frame msb first; csv high only to send ignored traffic
    task automatic xfer(input cpc_cmd_t c, input int nb, input logic csv,
                        output logic [DATA_W-1:0] q);
        logic [FRAME_BITS_CHK-1:0] sh;
        sh = {c, 8'h00};
        q = '0;
        cs_n = csv;
        #32;
        for (int i = 0; i < nb; i++) begin
            sdi = sh[FRAME_BITS_CHK-1-i];
            #32 sclk = 1'b1;
            if (i >= 8 && i < 32) begin
                q = {q[DATA_W-2:0], miso};
            end
            #32 sclk = 1'b0;
        end
        #32 cs_n = 1'b1;
        sdi = ~sdi;
        #64;
    endtask
endmodule

//--- tb/tb_converter_pin_control.sv
`timescale 1ns/10ps
module tb_converter_pin_control;
    import cpc_pkg::*;

    localparam int DIV_TB = 4096;
    logic mclk;
    logic resetn;
    cpc_strobe_t stb;
    logic sclk, cs_n, sdi, sdo_o, sdo_oe;
    logic ready_n, int_o, int_oe, dac_out_en;
    logic wiring_switch_on, adc_run, filter_clear;
    logic [DATA_W-1:0] adc_result, dac_out, q;
    logic [NUM_INPUTS-1:0] inputs_in_use, inputs_free;
    int error_cnt = 0;
    int n_checks = 0;

    // ****************************************
    // device and host
    // ****************************************
    cpc_core #(.DIV(DIV_TB)) cpc_core_inst (
        .mclk(mclk), .resetn(resetn), .sync_in(stb.sync),
        .dac_load_strobe_n(stb.load_n), .rst_pin_n(stb.rst_n),
        .ready_n(ready_n), .int_o(int_o), .int_oe(int_oe),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .adc_result(adc_result), .dac_out(dac_out),
        .dac_out_en(dac_out_en), .inputs_in_use(inputs_in_use),
        .inputs_free(inputs_free), .wiring_switch_on(wiring_switch_on),
        .adc_run(adc_run), .filter_clear(filter_clear)
    );

    cpc_host cpc_host_inst (
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input int nb = 32);
        cpc_host_inst.xfer(cpc_cmd_t'{a, 1'b1, d}, nb, 1'b0, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input int nb = 32);
        cpc_host_inst.xfer(cpc_cmd_t'{a, 1'b0, 24'h000000}, nb, 1'b0, q);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic load_pulse;
        cyc(1);
        stb.load_n <= 1'b0;
        cyc(4);
        stb.load_n <= 1'b1;
        cyc(6);
    endtask

    task automatic conclude;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        chk(ready_n, 1'b1);
        chk(int_oe, 1'b0);
        chk(sdo_oe, 1'b0);
        chk(dac_out, DAC_RESET);
        rd(ADDR_CFG);
        chk(q, CFG_RESET);
    endtask

    task automatic t_modes;
        logic [NUM_INPUTS-1:0] m;
        logic [NUM_INPUTS-1:0] e;
        for (int k = 0; k < 5; k++) begin
            m = (k < 2) ? 8'hc7 : 8'hc0;
            e = (k == 0) ? 8'hc3 : (k == 1) ? 8'hc4 : 8'hc0;
            wr(ADDR_CFG, 24'(k));
            rd(ADDR_CFG);
            chk(q, 24'(k));
            chk(inputs_free & m, e);
            chk(inputs_in_use & m, m & ~e);
        end
        wr(ADDR_CFG, 24'h000010);
        cyc(4);
        chk(wiring_switch_on, 1'b1);
        wr(ADDR_CFG, 24'h000000);
        cyc(4);
        chk(wiring_switch_on, 1'b0);
    endtask

    task automatic t_ignore;
        wr(ADDR_CFG, 24'h000003);
        cpc_host_inst.xfer(cpc_cmd_t'{ADDR_CFG, 1'b1, 24'h000001}, 32,
                           1'b1, q);
        chk(sdo_oe, 1'b0);
        rd(ADDR_CFG);
        chk(q, 24'h000003);
    endtask

    task automatic t_crc;
        wr(ADDR_CFG, 24'h000020);
        wr(ADDR_DAC, 24'h012345, 40);
        rd(ADDR_DAC, 40);
        chk(q, 24'h012345);
        wr(ADDR_CFG, 24'h000000, 40);
        rd(ADDR_CFG);
        chk(q, 24'h000000);
    endtask

    task automatic t_dac;
        wr(ADDR_DAC, 24'h00abcd);
        chk(dac_out, DAC_RESET);
        load_pulse();
        chk(dac_out, 24'h00abcd);
        chk(dac_out_en, 1'b1);
        wr(ADDR_DAC, 24'h00abcd >> 1);
        load_pulse();
        chk(dac_out, 24'h0055e6);
    endtask

    task automatic t_rstpin;
        wr(ADDR_CFG, 24'h000012);
        cyc(1);
        stb.rst_n <= 1'b0;
        cyc(6);
        chk(dac_out, DAC_RESET);
        chk(dac_out_en, 1'b0);
        chk(adc_run, 1'b0);
        load_pulse();
        chk(dac_out, DAC_RESET);
        stb.rst_n <= 1'b1;
        cyc(6);
        rd(ADDR_CFG);
        chk(q, CFG_RESET);
        chk(adc_run, 1'b1);
        chk(dac_out_en, 1'b0);
    endtask

    task automatic t_ready;
        wr(ADDR_CFG, 24'h000002);
        wr(ADDR_INT_EN, 24'h000001);
        for (int i = 0; i < 2 * DIV_TB && ready_n !== 1'b0; i++) begin
            cyc(1);
        end
        chk(ready_n, 1'b0);
        cyc(4);
        chk(int_oe, 1'b1);
        chk(int_o, 1'b0);
        rd(ADDR_ADC);
        chk(q, adc_result);
        cyc(6);
        chk(ready_n, 1'b1);
        wr(ADDR_INT_EN, 24'h000000);
        cyc(4);
        chk(int_oe, 1'b0);
    endtask

    task automatic t_sync;
        cyc(1);
        stb.sync <= 1'b1;
        cyc(5);
        chk(filter_clear, 1'b1);
        stb.sync <= 1'b0;
        cyc(6);
        chk(filter_clear, 1'b0);
    endtask

    // ****************************************
    // clock, sequence and watchdog
    // ****************************************
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        resetn = 1'b0;
        stb = cpc_strobe_t'{1'b0, 1'b1, 1'b1};
        adc_result = 24'h5a3c96;
        cyc(12);
        resetn <= 1'b1;
        cyc(8);
        t_reset();
        t_modes();
        t_ignore();
        t_crc();
        t_dac();
        t_rstpin();
        t_ready();
        t_sync();
        conclude();
    end

    initial begin
        #400us;
        error_cnt++;
        conclude();
    end
endmodule
